/* File: sec_core.sv */
// module: serial eeprom command port, decoder, read streamer and program engine
//
// What this block does
// RULE1: host waits up to 1 ms after supply stable before reads or writes.
// RULE2: instruction is 11 bits in sixteen-bit mode, 12 bits in byte mode.
// RULE3: input bits are sampled on each rising serial clock edge.
// RULE4: output floats except during read data or ready/busy status.
// RULE5: status shows low while busy, high once ready, with chip select high.
// RULE6: shifting a 1 while selected floats the status output at that edge.
// RULE7: start bit 1, two-bit opcode, address, then data for write types.
// RULE8: opcode 10 reads, 11 erases, 01 writes the addressed word.
// RULE9: opcode 00 uses top address bits: enable, disable, erase all, write all.
// RULE10: read sends one leading zero then the word, msb first, on rising edges.
// RULE11: continued clocking reads the next word, wrapping from last to 0.
// RULE12: only the first word of a sequential read has the leading zero.
// RULE13: programming disabled at power-up until enable; stays until disable.
// RULE14: reads work whether programming is enabled or not.
// RULE15: write-type cycles start on the falling edge of chip select.
// RULE16: a started cycle completes without further serial clock edges.
// RULE17: a write clears the location itself; no prior erase needed.
// RULE18: erase sets every bit of the addressed location to one.
// RULE19: erase all sets every bit of the array to one.
// RULE20: write all stores the data word into every location.
// RULE21: each programming cycle reports ready within 5 ms of its start.
// RULE22: a static input selects sixteen-bit or eight-bit organisation.
`timescale 1ns/1ps
module sec_core #(
	parameter int PROG_CYCLES = sec_pkg::PROG_CYCLES,
	parameter int FIFO_DEPTH  = sec_pkg::FIFO_DEPTH
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire sec_pkg::sec_pins_t pins,
	input  wire logic               word_width_select,
	output logic                    serial_out,
	output logic                    serial_out_oe
);
	localparam int TW = $clog2(PROG_CYCLES + 1);
	localparam logic [TW-1:0] TIMER_LOAD = TW'(PROG_CYCLES - 1);

	if (PROG_CYCLES <= sec_pkg::MEM_BYTES) begin : g_bad_prog
		$error("program cycle count too short for a full array sweep");
	end

	logic                 cs;
	logic                 sck;
	logic                 din;
	logic                 x16;
	logic                 sck_rise;
	logic                 prog_start;
	logic [15:0]          sh_next;
	logic [1:0]           opc_now;
	logic [1:0]           ext_now;
	logic [8:0]           adr_now;
	logic [4:0]           hdr_last;
	logic [4:0]           data_last;
	logic [3:0]           dw_msb;
	logic [15:0]          rd_word;
	logic [7:0]           wbyte;
	logic                 fifo_flush;
	logic                 fifo_pop;
	logic                 fifo_in_ready;
	logic                 fifo_out_valid;
	logic [15:0]          fifo_out_data;
	logic [7:0]           mem [sec_pkg::MEM_BYTES];

	sec_pkg::sec_state_t  st_q;
	sec_pkg::sec_state_t  st_d;
	sec_pkg::sec_job_t    job_q;
	sec_pkg::sec_job_t    job_d;
	logic                 sck_prev_q;
	logic                 cs_prev_q;
	logic [4:0]           cnt_q;
	logic [4:0]           cnt_d;
	logic [15:0]          sh_q;
	logic [15:0]          sh_d;
	logic                 wen_q;
	logic                 wen_d;
	logic                 status_q;
	logic                 status_d;
	logic [15:0]          rd_sh_q;
	logic [15:0]          rd_sh_d;
	logic [3:0]           rd_cnt_q;
	logic [3:0]           rd_cnt_d;
	logic                 out_q;
	logic                 out_d;
	logic                 oe_q;
	logic                 oe_d;
	logic [8:0]           pf_addr_q;
	logic [8:0]           pf_addr_d;
	logic                 pf_act_q;
	logic                 pf_act_d;
	logic                 busy_q;
	logic                 busy_d;
	logic [TW-1:0]        timer_q;
	logic [TW-1:0]        timer_d;
	logic                 sweep_q;
	logic                 sweep_d;
	logic [8:0]           idx_q;
	logic [8:0]           idx_d;
	logic [8:0]           idx_end_q;
	logic [8:0]           idx_end_d;
	int unsigned          busy_cyc_q;

	// =========================================================
	// pin decode and organisation
	assign cs         = pins.chip_select;
	assign sck        = pins.serial_clock_in;
	assign din        = pins.serial_in;
	assign x16        = word_width_select; // RULE22
	assign sck_rise   = sck && !sck_prev_q; // RULE3
	assign hdr_last   = x16 ? 5'(sec_pkg::HDR_BITS_X16 - 1) : 5'(sec_pkg::HDR_BITS_X8 - 1); // RULE2
	assign data_last  = x16 ? 5'(sec_pkg::DATA_W_X16 - 1) : 5'(sec_pkg::DATA_W_X8 - 1);
	assign dw_msb     = x16 ? 4'(sec_pkg::DATA_W_X16 - 1) : 4'(sec_pkg::DATA_W_X8 - 1);
	assign sh_next    = {sh_q[14:0], din};
	assign opc_now    = x16 ? sh_next[9:8] : sh_next[10:9]; // RULE7
	assign ext_now    = x16 ? sh_next[7:6] : sh_next[8:7]; // RULE9
	assign adr_now    = x16 ? {1'b0, sh_next[7:0]} : sh_next[8:0];
	assign prog_start = (st_q == sec_pkg::SEC_S_PEND) && cs_prev_q && !cs && wen_q; // RULE15
	assign serial_out    = out_q;
	assign serial_out_oe = oe_q;

	// =========================================================
	// array read and prefetch fifo
	always_comb begin
		if (x16) rd_word = {mem[{pf_addr_q[7:0], 1'b0}], mem[{pf_addr_q[7:0], 1'b1}]};
		else rd_word = {8'h00, mem[pf_addr_q]};
	end

	sec_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.flush     (fifo_flush),
		.in_valid  (pf_act_q),
		.in_ready  (fifo_in_ready),
		.in_data   (rd_word),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// =========================================================
	// command shifter, read streamer and output pin
	always_comb begin
		st_d       = st_q;
		cnt_d      = cnt_q;
		sh_d       = sh_q;
		wen_d      = wen_q;
		status_d   = status_q;
		job_d      = job_q;
		rd_sh_d    = rd_sh_q;
		rd_cnt_d   = rd_cnt_q;
		out_d      = out_q;
		oe_d       = oe_q;
		pf_addr_d  = pf_addr_q;
		pf_act_d   = pf_act_q;
		fifo_flush = 1'b0;
		fifo_pop   = 1'b0;
		if (prog_start) status_d = 1'b1; // RULE5
		if (pf_act_q && fifo_in_ready) begin
			if (x16) pf_addr_d = {1'b0, pf_addr_q[7:0] + 8'h01}; // RULE11
			else pf_addr_d = pf_addr_q + 9'h001; // RULE11
		end
		if (!cs) begin
			st_d       = sec_pkg::SEC_S_IDLE;
			pf_act_d   = 1'b0;
			fifo_flush = 1'b1;
		end else if (sck_rise) begin
			if (status_q && din) status_d = 1'b0; // RULE6
			case (st_q)
				sec_pkg::SEC_S_IDLE: begin
					if (din && !busy_q) begin // RULE7
						st_d  = sec_pkg::SEC_S_CMD;
						cnt_d = 5'h00;
						sh_d  = 16'h0000;
					end
				end
				sec_pkg::SEC_S_CMD: begin
					sh_d  = sh_next;
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == hdr_last) begin
						cnt_d      = 5'h00;
						job_d.addr = adr_now;
						case (opc_now) // RULE8
							sec_pkg::OPC_READ: begin
								st_d       = sec_pkg::SEC_S_READ; // RULE14
								out_d      = 1'b0; // RULE10
								rd_cnt_d   = 4'h0;
								pf_addr_d  = adr_now;
								pf_act_d   = 1'b1;
								fifo_flush = 1'b1;
							end
							sec_pkg::OPC_ERASE: begin
								job_d.kind = sec_pkg::SEC_J_ERASE;
								st_d       = sec_pkg::SEC_S_PEND;
							end
							sec_pkg::OPC_WRITE: begin
								job_d.kind = sec_pkg::SEC_J_WRITE;
								st_d       = sec_pkg::SEC_S_DATA;
							end
							default: begin
								case (ext_now) // RULE9
									sec_pkg::EXT_ENABLE: begin
										wen_d = 1'b1; // RULE13
										st_d  = sec_pkg::SEC_S_DONE;
									end
									sec_pkg::EXT_DISABLE: begin
										wen_d = 1'b0; // RULE13
										st_d  = sec_pkg::SEC_S_DONE;
									end
									sec_pkg::EXT_ERALL: begin
										job_d.kind = sec_pkg::SEC_J_ERALL;
										st_d       = sec_pkg::SEC_S_PEND;
									end
									default: begin
										job_d.kind = sec_pkg::SEC_J_WRALL;
										st_d       = sec_pkg::SEC_S_DATA;
									end
								endcase
							end
						endcase
					end
				end
				sec_pkg::SEC_S_DATA: begin
					sh_d  = sh_next;
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == data_last) begin
						job_d.data = x16 ? sh_next : {8'h00, sh_next[7:0]};
						st_d       = sec_pkg::SEC_S_PEND;
					end
				end
				sec_pkg::SEC_S_READ: begin
					if (rd_cnt_q == 4'h0) begin
						if (fifo_out_valid) begin // RULE12
							fifo_pop = 1'b1;
							out_d    = fifo_out_data[dw_msb];
							rd_sh_d  = {fifo_out_data[14:0], 1'b0};
							rd_cnt_d = dw_msb;
						end
					end else begin
						out_d    = rd_sh_q[dw_msb]; // RULE10
						rd_sh_d  = {rd_sh_q[14:0], 1'b0};
						rd_cnt_d = rd_cnt_q - 4'h1;
					end
				end
				default: begin
				end
			endcase
		end
		if (!cs) begin
			oe_d = 1'b0; // RULE4
		end else if (st_d == sec_pkg::SEC_S_READ) begin
			oe_d = 1'b1;
		end else if (status_d) begin
			oe_d  = 1'b1;
			out_d = !busy_q; // RULE5
		end else begin
			oe_d = 1'b0; // RULE4
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q       <= sec_pkg::SEC_S_IDLE;
			sck_prev_q <= 1'b0;
			cs_prev_q  <= 1'b0;
			cnt_q      <= 5'h00;
			sh_q       <= 16'h0000;
			wen_q      <= 1'b0;
			status_q   <= 1'b0;
			job_q      <= '{sec_pkg::SEC_J_WRITE, 9'h000, 16'h0000};
			rd_sh_q    <= 16'h0000;
			rd_cnt_q   <= 4'h0;
			out_q      <= 1'b0;
			oe_q       <= 1'b0;
			pf_addr_q  <= 9'h000;
			pf_act_q   <= 1'b0;
		end else begin
			st_q       <= st_d;
			sck_prev_q <= sck;
			cs_prev_q  <= cs;
			cnt_q      <= cnt_d;
			sh_q       <= sh_d;
			wen_q      <= wen_d;
			status_q   <= status_d;
			job_q      <= job_d;
			rd_sh_q    <= rd_sh_d;
			rd_cnt_q   <= rd_cnt_d;
			out_q      <= out_d;
			oe_q       <= oe_d;
			pf_addr_q  <= pf_addr_d;
			pf_act_q   <= pf_act_d;
		end
	end

	// =========================================================
	// self-timed program engine
	always_comb begin
		if (job_q.kind == sec_pkg::SEC_J_ERASE || job_q.kind == sec_pkg::SEC_J_ERALL) begin
			wbyte = sec_pkg::ERASED_BYTE; // RULE18
		end else if (x16) begin
			wbyte = idx_q[0] ? job_q.data[7:0] : job_q.data[15:8];
		end else begin
			wbyte = job_q.data[7:0];
		end
	end

	always_comb begin
		busy_d    = busy_q;
		timer_d   = timer_q;
		sweep_d   = sweep_q;
		idx_d     = idx_q;
		idx_end_d = idx_end_q;
		if (prog_start) begin
			busy_d  = 1'b1;
			timer_d = TIMER_LOAD; // RULE21
			sweep_d = 1'b1;
			if (job_q.kind == sec_pkg::SEC_J_ERALL || job_q.kind == sec_pkg::SEC_J_WRALL) begin
				idx_d     = 9'h000; // RULE19
				idx_end_d = 9'(sec_pkg::MEM_BYTES - 1); // RULE20
			end else if (x16) begin
				idx_d     = {job_q.addr[7:0], 1'b0};
				idx_end_d = {job_q.addr[7:0], 1'b1};
			end else begin
				idx_d     = job_q.addr;
				idx_end_d = job_q.addr;
			end
		end else begin
			if (sweep_q) begin
				if (idx_q == idx_end_q) sweep_d = 1'b0;
				else idx_d = idx_q + 9'h001;
			end
			if (busy_q) begin // RULE16
				if (timer_q == '0) busy_d = 1'b0;
				else timer_d = timer_q - TW'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_q    <= 1'b0;
			timer_q   <= '0;
			sweep_q   <= 1'b0;
			idx_q     <= 9'h000;
			idx_end_q <= 9'h000;
		end else begin
			busy_q    <= busy_d;
			timer_q   <= timer_d;
			sweep_q   <= sweep_d;
			idx_q     <= idx_d;
			idx_end_q <= idx_end_d;
		end
	end

	// write overwrites in place, so no separate clear pass
	always_ff @(posedge clk) begin
		if (sweep_q) mem[idx_q] <= wbyte; // RULE17
	end

	// =========================================================
	// checks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) busy_cyc_q <= 0;
		else if (busy_q) busy_cyc_q <= busy_cyc_q + 1;
		else busy_cyc_q <= 0;
	end

	AST_OE_DESELECT: // RULE4
	assert property (@(posedge clk) disable iff (rst) !cs |=> !serial_out_oe)
		else $error("output driven while deselected");
	AST_STATUS_BUSY: // RULE5
	assert property (@(posedge clk) disable iff (rst)
		(status_q && cs && !sck_rise && busy_q) |=> (serial_out_oe && !serial_out))
		else $error("busy status not shown low");
	AST_STATUS_READY: // RULE5
	assert property (@(posedge clk) disable iff (rst)
		(status_q && cs && !sck_rise && !busy_q) |=> (serial_out_oe && serial_out))
		else $error("ready status not shown high");
	AST_STATUS_FLOAT: // RULE6
	assert property (@(posedge clk) disable iff (rst)
		(status_q && cs && sck_rise && din && st_q == sec_pkg::SEC_S_IDLE) |=> !serial_out_oe)
		else $error("status output not floated by a shifted one");
	AST_READ_DUMMY: // RULE10
	assert property (@(posedge clk) disable iff (rst)
		(cs && sck_rise && st_q == sec_pkg::SEC_S_CMD && cnt_q == hdr_last
			&& opc_now == sec_pkg::OPC_READ) |=> (serial_out_oe && !serial_out))
		else $error("leading zero of read missing");
	AST_READ_ANY_ENABLE: // RULE14
	assert property (@(posedge clk) disable iff (rst)
		(cs && sck_rise && st_q == sec_pkg::SEC_S_CMD && cnt_q == hdr_last
			&& opc_now == sec_pkg::OPC_READ) |=> st_q == sec_pkg::SEC_S_READ)
		else $error("read not started");
	AST_READ_STREAM: // RULE12
	assert property (@(posedge clk) disable iff (rst)
		(st_q == sec_pkg::SEC_S_READ && cs) |=> serial_out_oe)
		else $error("output released inside a read");
	AST_START_ENABLED: // RULE13
	assert property (@(posedge clk) disable iff (rst) $rose(busy_q) |-> $past(wen_q))
		else $error("programming started while disabled");
	AST_START_ON_FALL: // RULE15
	assert property (@(posedge clk) disable iff (rst)
		$rose(busy_q) |-> ($past(cs_prev_q) && !$past(cs)))
		else $error("programming not started by chip select fall");
	AST_CYCLE_BOUND: // RULE21
	assert property (@(posedge clk) disable iff (rst) busy_cyc_q <= PROG_CYCLES)
		else $error("programming cycle too long");
	AST_SWEEP_IN_BUSY: // RULE16
	assert property (@(posedge clk) disable iff (rst) sweep_q |-> busy_q)
		else $error("array write outside a programming cycle");

endmodule

/* File: sec_fifo.sv */
// module: read prefetch fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
module sec_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_shape
		$error("fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      wr_d;
	logic [AW:0]      rd_q;
	logic [AW:0]      rd_d;
	logic             push;
	logic             pop;

	// =========================================================
	// pointers
	assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign out_valid = (wr_q != rd_q);
	assign out_data  = mem[rd_q[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		if (flush) begin
			wr_d = '0;
			rd_d = '0;
		end else begin
			if (push) wr_d = wr_q + (AW+1)'(1);
			if (pop) rd_d = rd_q + (AW+1)'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	always_ff @(posedge clk) begin
		if (push && !flush) mem[wr_q[AW-1:0]] <= in_data;
	end

	// =========================================================
	// checks
	AST_FIFO_BOUND:
	assert property (@(posedge clk) disable iff (rst) (wr_q - rd_q) <= (AW+1)'(DEPTH))
		else $error("fifo occupancy above depth");
	AST_FIFO_FULL_HOLD:
	assert property (@(posedge clk) disable iff (rst)
		(!in_ready && !pop && !flush) |=> (wr_q == $past(wr_q)))
		else $error("fifo written while full");

endmodule

/* File: sec_host.sv */
// host model: bit-bangs chip select, serial clock and serial data
`timescale 1ns/1ps
module sec_host (
	input  wire logic          clk,
	output sec_pkg::sec_pins_t pins,
	input  wire logic          serial_out,
	input  wire logic          serial_out_oe
);
	// =========================================================
	// pacing
	localparam int HALF = 13;

	initial pins = '0;

	// =========================================================
	// pin tasks
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic select(input logic v);
		pins.chip_select = v;
		pins.serial_clock_in = 1'b0;
		idle(HALF);
	endtask

	task automatic open_frame();
		select(1'b1);
	endtask

	task automatic close_frame();
		select(1'b0);
	endtask

	task automatic tick(input logic b, output logic so, output logic oe);
		pins.serial_in = b;
		pins.serial_clock_in = 1'b0;
		idle(HALF);
		pins.serial_clock_in = 1'b1;
		idle(HALF);
		so = serial_out;
		oe = serial_out_oe;
	endtask

	task automatic send(input logic [27:0] bits, input int n, output logic so, output logic oe);
		for (int i = n - 1; i >= 0; i--) begin
			tick(bits[i], so, oe);
		end
	endtask
endmodule

/* File: sec_pkg.sv */
// package: constants, states and carriers of the serial eeprom command port
package sec_pkg;

	// =========================================================
	// timing
	localparam int CLK_HZ       = 50_000_000;
	localparam int PROG_TIME_MS = 5;
	localparam int PROG_CYCLES  = PROG_TIME_MS * (CLK_HZ / 1000);

	// =========================================================
	// array and instruction layout
	localparam int MEM_BYTES    = 512;
	localparam int ADDR_W_X16   = 8;
	localparam int ADDR_W_X8    = 9;
	localparam int DATA_W_X16   = 16;
	localparam int DATA_W_X8    = 8;
	localparam int OPC_W        = 2;
	localparam int HDR_BITS_X16 = OPC_W + ADDR_W_X16;
	localparam int HDR_BITS_X8  = OPC_W + ADDR_W_X8;
	localparam int FIFO_DEPTH   = 16;

	localparam logic [1:0] OPC_EXT     = 2'h0;
	localparam logic [1:0] OPC_WRITE   = 2'h1;
	localparam logic [1:0] OPC_READ    = 2'h2;
	localparam logic [1:0] OPC_ERASE   = 2'h3;
	localparam logic [1:0] EXT_DISABLE = 2'h0;
	localparam logic [1:0] EXT_WRALL   = 2'h1;
	localparam logic [1:0] EXT_ERALL   = 2'h2;
	localparam logic [1:0] EXT_ENABLE  = 2'h3;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// =========================================================
	// types
	typedef enum logic [2:0] {
		SEC_S_IDLE = 3'b000,
		SEC_S_CMD  = 3'b001,
		SEC_S_DATA = 3'b010,
		SEC_S_READ = 3'b011,
		SEC_S_PEND = 3'b100,
		SEC_S_DONE = 3'b101
	} sec_state_t;

	typedef enum logic [1:0] {
		SEC_J_WRITE = 2'b00,
		SEC_J_ERASE = 2'b01,
		SEC_J_WRALL = 2'b10,
		SEC_J_ERALL = 2'b11
	} sec_job_kind_t;

	typedef struct packed {
		sec_job_kind_t kind;
		logic [8:0]    addr;
		logic [15:0]   data;
	} sec_job_t;

	typedef struct packed {
		logic chip_select;
		logic serial_clock_in;
		logic serial_in;
	} sec_pins_t;

endpackage

/* File: tb_serial_eeprom_command_port.sv */
// testbench: serial eeprom command port against a bit-banging host
`timescale 1ns/1ps
module tb_serial_eeprom_command_port;
	localparam int PROG = 600;

	logic               clk;
	logic               rst;
	logic               word_width_select;
	sec_pkg::sec_pins_t pins;
	logic               serial_out;
	logic               serial_out_oe;
	int                 err_total;
	int                 checks;
	logic               so;
	logic               oe;
	logic [15:0]        w;

	sec_core #(.PROG_CYCLES(PROG), .FIFO_DEPTH(sec_pkg::FIFO_DEPTH)) dut (
		.clk               (clk),
		.rst               (rst),
		.pins              (pins),
		.word_width_select (word_width_select),
		.serial_out        (serial_out),
		.serial_out_oe     (serial_out_oe)
	);

	sec_host host (
		.clk           (clk),
		.pins          (pins),
		.serial_out    (serial_out),
		.serial_out_oe (serial_out_oe)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// =========================================================
	// helpers
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		if (err_total == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	function automatic logic [27:0] op16(input logic [1:0] op, input logic [7:0] a);
		return {17'h0, 1'b1, op, a};
	endfunction

	function automatic logic [27:0] wr16(input logic [1:0] op, input logic [7:0] a,
		input logic [15:0] d);
		return {1'h0, 1'b1, op, a, d};
	endfunction

	task automatic hdr(input logic [27:0] bits, input int n);
		host.open_frame();
		host.send(bits, n, so, oe);
	endtask

	task automatic cmd_only(input logic [27:0] bits, input int n);
		hdr(bits, n);
		host.close_frame();
	endtask

	task automatic prog(input logic [27:0] bits, input int n);
		int i;
		hdr(bits, n);
		host.close_frame();
		host.open_frame();
		chk({14'h0, serial_out_oe, serial_out}, 16'h0002);
		for (i = 0; i < PROG && serial_out !== 1'b1; i++) begin
			@(negedge clk);
		end
		chk({14'h0, serial_out_oe, serial_out}, 16'h0003);
		if (serial_out !== 1'b1) begin
			conclude();
		end
		host.tick(1'b1, so, oe);
		chk({15'h0, oe}, 16'h0000);
		host.close_frame();
	endtask

	task automatic get(input int dw);
		w = '0;
		for (int i = 0; i < dw; i++) begin
			host.tick(1'b0, so, oe);
			w = {w[14:0], so};
		end
	endtask

	task automatic rd(input logic [27:0] bits, input int n, input int dw,
		input logic [15:0] e0, input logic [15:0] e1);
		hdr(bits, n);
		chk({14'h0, oe, so}, 16'h0002);
		get(dw);
		chk(w, e0);
		get(dw);
		chk(w, e1);
		host.close_frame();
		chk({15'h0, serial_out_oe}, 16'h0000);
	endtask

	// =========================================================
	// scenarios
	task automatic sc_reset();
		chk({15'h0, serial_out_oe}, 16'h0000);
		cmd_only(wr16(sec_pkg::OPC_WRITE, 8'h03, 16'h5555), 27);
		host.open_frame();
		chk({15'h0, serial_out_oe}, 16'h0000);
		host.close_frame();
	endtask

	task automatic sc_erall();
		cmd_only(op16(sec_pkg::OPC_EXT, {sec_pkg::EXT_ENABLE, 6'h00}), 11);
		prog(op16(sec_pkg::OPC_EXT, {sec_pkg::EXT_ERALL, 6'h15}), 11);
		rd(op16(sec_pkg::OPC_READ, 8'h00), 11, 16, 16'hFFFF, 16'hFFFF);
	endtask

	task automatic sc_write();
		prog(wr16(sec_pkg::OPC_WRITE, 8'h05, 16'hA5C3), 27);
		rd(op16(sec_pkg::OPC_READ, 8'h05), 11, 16, 16'hA5C3, 16'hFFFF);
		prog(wr16(sec_pkg::OPC_WRITE, 8'hFF, 16'h0F0F), 27);
		rd(op16(sec_pkg::OPC_READ, 8'hFF), 11, 16, 16'h0F0F, 16'hFFFF);
		prog(op16(sec_pkg::OPC_ERASE, 8'h05), 11);
		rd(op16(sec_pkg::OPC_READ, 8'h04), 11, 16, 16'hFFFF, 16'hFFFF);
	endtask

	task automatic sc_wrall();
		prog(wr16(sec_pkg::OPC_EXT, {sec_pkg::EXT_WRALL, 6'h2A}, 16'h1234), 27);
		rd(op16(sec_pkg::OPC_READ, 8'h09), 11, 16, 16'h1234, 16'h1234);
	endtask

	task automatic sc_disable();
		cmd_only(op16(sec_pkg::OPC_EXT, {sec_pkg::EXT_DISABLE, 6'h3F}), 11);
		cmd_only(wr16(sec_pkg::OPC_WRITE, 8'h09, 16'hBEEF), 27);
		host.open_frame();
		chk({15'h0, serial_out_oe}, 16'h0000);
		host.close_frame();
		rd(op16(sec_pkg::OPC_READ, 8'h09), 11, 16, 16'h1234, 16'h1234);
	endtask

	task automatic sc_bytes();
		word_width_select = 1'b0;
		rd({16'h0, 1'b1, sec_pkg::OPC_READ, 9'h000}, 12, 8, 16'h0012, 16'h0034);
		cmd_only({16'h0, 1'b1, sec_pkg::OPC_EXT, sec_pkg::EXT_ENABLE, 7'h00}, 12);
		prog({8'h0, 1'b1, sec_pkg::OPC_WRITE, 9'h003, 8'h5A}, 28);
		rd({16'h0, 1'b1, sec_pkg::OPC_READ, 9'h002}, 12, 8, 16'h0012, 16'h005A);
		word_width_select = 1'b1;
	endtask

	// =========================================================
	// main sequence
	initial begin
		rst = 1'b1;
		word_width_select = 1'b1;
		err_total = 0;
		checks = 0;
		repeat (20) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		sc_reset();
		sc_erall();
		sc_write();
		sc_wrall();
		sc_disable();
		sc_bytes();
		conclude();
	end
endmodule
